// [rtl/oramx_pkg.sv]
/*
  Package for the or/and-move execute block: opcode fields, widths, reset values.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
package oramx_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int DEST_BIT = 7;
  localparam logic [5:0] OR_LITERAL_OP = 6'h38;
  localparam logic [5:0] OR_REGISTER_OP = 6'h04;
  localparam logic [5:0] COPY_REGISTER_OP = 6'h08;
  localparam logic [3:0] LOAD_LITERAL_OP = 4'hC;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [7:0] FILE_RESET = 8'h00;
  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } oramx_insn_t;
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } oramx_fwrite_t;
  typedef enum logic [3:0] {
    OP_NONE = 4'h1,
    OP_ORL = 4'h2,
    OP_ORF = 4'h4,
    OP_MOVE = 4'h8
  } oramx_op_t;
endpackage

// [rtl/oramx_file.sv]
/*
  File register storage: flip-flops addressed by index, one combinational read
  port and one write port. Assumes a single clock and synchronous reset.
*/
`timescale 1ns/1ps
module oramx_file #(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata
);
  import oramx_pkg::*;
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] next_mem [DEPTH];

  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("depth exceeds address range");
  end

  assign o_rdata = mem[i_raddr];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
    end
    if (i_we) begin
      next_mem[i_waddr] = i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] <= i_rst ? DW'(FILE_RESET) : next_mem[i];
    end
  end
endmodule

// [rtl/oramx_exec.sv]
/*
  Decode and single-cycle execute of four instructions: or literal, or register,
  load literal and copy register, with accumulator, zero flag and file registers.
  Assumes one valid instruction word per clock; other opcodes pass unexecuted.
*/
// What this block does
// [RULE1] Or-literal ORs the accumulator with the literal into the accumulator and updates zero.
// [RULE2] Or-register ORs the accumulator with the addressed file register and updates zero.
// [RULE3] Or-register writes the accumulator when the destination bit is 0, the file when 1.
// [RULE4] Load-literal puts the literal in the accumulator and leaves the zero flag alone.
// [RULE5] Load-literal is accepted whatever its two don't-care bits hold.
// [RULE6] Copy-register forwards the file value to the destination and sets zero from it.
// [RULE7] Copy-register writes the accumulator when the destination bit is 0, the file when 1.
// [RULE8] Copy-register back to the same register still updates zero, acting as a test.
// [RULE9] Each instruction is one word and completes in one cycle with no skip.
// [RULE10] Bit 7 is the destination select and bits 6..0 the file address 0 to 127.
`timescale 1ns/1ps
module oramx_exec #(
  parameter int FILE_DEPTH = 128
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire oramx_pkg::oramx_insn_t i_insn,
  output logic [oramx_pkg::DATA_W-1:0] o_acc,
  output logic o_zero,
  output logic o_done,
  output oramx_pkg::oramx_fwrite_t o_fwrite
);
  import oramx_pkg::*;

  // the address field is seven bits wide, so at most 128 registers exist
  if (FILE_DEPTH < 1 || FILE_DEPTH > (1 << ADDR_W)) begin : g_bad_depth
    $error("file depth must be 1..128");
  end
  // the destination select must sit just above the address field
  if (DEST_BIT != ADDR_W) begin : g_bad_field
    $error("destination bit must follow the address field");
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  oramx_op_t op;
  logic dest;
  logic [ADDR_W-1:0] faddr;
  logic [DATA_W-1:0] lit;
  logic [DATA_W-1:0] fdata;

  // load literal is caught by is_load below, since its two low opcode bits
  // are don't-cares and do not fit the six-bit compares
  always_comb begin
    op = OP_NONE;
    if (i_insn.valid) begin
      if (i_insn.word[13:8] == OR_LITERAL_OP) begin
        op = OP_ORL;
      end else if (i_insn.word[13:10] == LOAD_LITERAL_OP) begin
        op = OP_NONE;
      end else if (i_insn.word[13:8] == OR_REGISTER_OP) begin
        op = OP_ORF;
      end else if (i_insn.word[13:8] == COPY_REGISTER_OP) begin
        op = OP_MOVE;
      end
    end
  end

  logic is_load;
  assign is_load = i_insn.valid && i_insn.word[13:10] == LOAD_LITERAL_OP; // [RULE5]
  assign dest = i_insn.word[DEST_BIT]; // [RULE10]
  assign faddr = i_insn.word[ADDR_W-1:0]; // [RULE10]
  assign lit = i_insn.word[DATA_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // execute
  logic [DATA_W-1:0] acc;
  logic zero;
  logic done;
  oramx_fwrite_t fw;
  logic [DATA_W-1:0] next_acc;
  logic next_zero;
  logic next_done;
  oramx_fwrite_t next_fw;
  logic [DATA_W-1:0] result;

  // the write port takes the next value, so a write-back lands on the same
  // edge that ends the instruction and the next word already reads it
  oramx_file #(
    .DEPTH(FILE_DEPTH),
    .AW(ADDR_W),
    .DW(DATA_W)
  ) u_file (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_raddr(faddr),
    .o_rdata(fdata),
    .i_we(next_fw.en),
    .i_waddr(next_fw.addr),
    .i_wdata(next_fw.data)
  );

  // load literal never touches the zero flag; the or and copy forms always
  // do, whichever destination they pick
  always_comb begin
    next_acc = acc;
    next_zero = zero;
    next_done = 1'b0;
    next_fw = '0;
    result = '0;
    next_fw.addr = faddr;
    if (is_load) begin
      next_acc = lit; // [RULE4]
      next_done = 1'b1;
    end else begin
      case (op)
        OP_ORL: begin
          result = acc | lit;
          next_acc = result; // [RULE1]
          next_zero = (result == '0);
          next_done = 1'b1;
        end
        OP_ORF, OP_MOVE: begin
          result = (op == OP_ORF) ? (acc | fdata) : fdata; // [RULE2] [RULE6]
          next_zero = (result == '0); // [RULE8]
          if (dest) begin
            next_fw.en = 1'b1; // [RULE3] [RULE7]
            next_fw.data = result;
          end else begin
            next_acc = result;
          end
          next_done = 1'b1; // [RULE9]
        end
        OP_NONE: begin
        end
        default: begin
        end
      endcase
    end
  end

  // every output is taken straight from these registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      acc <= ACC_RESET;
      zero <= ZERO_RESET;
      done <= 1'b0;
      fw <= '0;
    end else begin
      acc <= next_acc;
      zero <= next_zero;
      done <= next_done;
      fw <= next_fw;
    end
  end

  assign o_acc = acc;
  assign o_zero = zero;
  assign o_done = done;
  assign o_fwrite = fw;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // each property but a_fw_quiet looks one edge past the instruction, where the
  // registers hold its result; a_fw_quiet checks the same edge; cycles in reset are masked
  a_orl_result: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE1]
    (i_insn.valid && i_insn.word[13:8] == OR_LITERAL_OP)
    |=> (acc == ($past(acc) | $past(lit))) && (zero == (acc == 8'h00)))
    else $error("or literal result wrong");

  a_orl_nowrite: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE1]
    (op == OP_ORL) |=> !fw.en)
    else $error("or literal wrote a file register");

  a_orf_zero: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE2]
    (op == OP_ORF) |=> zero == ((($past(acc) | $past(fdata))) == 8'h00))
    else $error("or register zero wrong");

  a_orf_acc: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE3]
    (op == OP_ORF && !dest) |=> acc == ($past(acc) | $past(fdata)) && !fw.en)
    else $error("or register accumulator wrong");

  a_orf_dest: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE3]
    (op == OP_ORF && dest) |=> fw.en && fw.data == ($past(acc) | $past(fdata))
      && acc == $past(acc))
    else $error("or register destination wrong");

  a_load_keep: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE4]
    (i_insn.valid && i_insn.word[13:12] == 2'h3 && i_insn.word[11:10] == 2'h0)
    |=> acc == $past(lit) && $stable(zero))
    else $error("load literal wrong");

  a_load_nowrite: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE4]
    is_load |=> !fw.en)
    else $error("load literal wrote a file register");

  a_load_dontcare: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE5]
    (i_insn.valid && i_insn.word[13:10] == 4'hC) |=> done)
    else $error("load literal not accepted");

  a_move_value: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE6]
    (op == OP_MOVE && !dest) |=> acc == $past(fdata))
    else $error("copy register value wrong");

  a_move_keep: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE7]
    (op == OP_MOVE && dest) |=> acc == $past(acc))
    else $error("copy register touched the accumulator");

  a_move_dest: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE7]
    (op == OP_MOVE) |=> fw.en == $past(dest) && fw.addr == $past(faddr))
    else $error("copy register destination wrong");

  a_move_test: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE8]
    (op == OP_MOVE && dest) |=> zero == ($past(fdata) == 8'h00) && fw.data == $past(fdata))
    else $error("copy register zero test wrong");

  // a recognised word shows done on the very next edge
  a_one_cycle: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE9]
    (op != OP_NONE || is_load) |=> done)
    else $error("instruction not single cycle");

  // anything else, a dropped valid too, clears done and leaves acc, zero and the file registers alone
  a_none_idle: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE9]
    (op == OP_NONE && !is_load) |=> !done && !fw.en && $stable(acc) && $stable(zero))
    else $error("refused word changed state");

  a_fw_quiet: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE9]
    !fw.en |-> fw.data == 8'h00)
    else $error("write data shown without a write");

  a_addr_field: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE10]
    (op == OP_ORF || op == OP_MOVE) |=> fw.addr == $past(i_insn.word[6:0]))
    else $error("file address field wrong");
endmodule

// [bench/oramx_exec_tb.sv]
/*
  Self-checking bench for the or/load/copy execute block.
  Assumes the package and the execute block compile first; no partner model.
*/
`timescale 1ns/1ps
module oramx_exec_tb;
  import oramx_pkg::*;
  logic i_clock;
  logic i_rst;
  oramx_insn_t i_insn;
  logic [DATA_W-1:0] o_acc;
  logic o_zero;
  logic o_done;
  oramx_fwrite_t o_fwrite;
  int n_fail;
  int n_checks;

  oramx_exec DUT (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_insn(i_insn),
    .o_acc(o_acc),
    .o_zero(o_zero),
    .o_done(o_done),
    .o_fwrite(o_fwrite)
  );

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  //////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // drive one word just after an edge, then look one edge later
  task op(input logic v, input logic [13:0] w);
    i_insn.valid = v;
    i_insn.word = w;
    @(posedge i_clock);
    #1;
  endtask

  task res(input logic [7:0] acc, input logic z, input logic dn, input logic en);
    chk("acc", 16'(o_acc), 16'(acc));
    chk("zero", 16'(o_zero), 16'(z));
    chk("done", 16'(o_done), 16'(dn));
    chk("fwrite_en", 16'(o_fwrite.en), 16'(en));
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task t_or_literal_load;
    op(1'b1, {OR_LITERAL_OP, 8'h00});
    res(8'h00, 1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      op(1'b1, {LOAD_LITERAL_OP, i[1:0], 8'h5A ^ 8'(i)});
      res(8'h5A ^ 8'(i), 1'b1, 1'b1, 1'b0);
    end
    op(1'b1, {LOAD_LITERAL_OP, 2'b00, 8'h9A});
    op(1'b1, {OR_LITERAL_OP, 8'h35});
    res(8'hBF, 1'b0, 1'b1, 1'b0);
    op(1'b1, {LOAD_LITERAL_OP, 2'b11, 8'h00});
    res(8'h00, 1'b0, 1'b1, 1'b0);
  endtask

  task t_or_register;
    op(1'b1, {LOAD_LITERAL_OP, 2'b00, 8'h13});
    op(1'b1, {OR_REGISTER_OP, 1'b1, 7'h7F});
    res(8'h13, 1'b0, 1'b1, 1'b1);
    chk("fwrite_addr", 16'(o_fwrite.addr), 16'h007F);
    chk("fwrite_data", 16'(o_fwrite.data), 16'h0013);
    op(1'b1, {LOAD_LITERAL_OP, 2'b00, 8'h80});
    op(1'b1, {OR_REGISTER_OP, 1'b0, 7'h7F});
    res(8'h93, 1'b0, 1'b1, 1'b0);
    op(1'b1, {LOAD_LITERAL_OP, 2'b00, 8'h00});
    op(1'b1, {OR_REGISTER_OP, 1'b0, 7'h00});
    res(8'h00, 1'b1, 1'b1, 1'b0);
  endtask

  task t_copy_register;
    op(1'b1, {COPY_REGISTER_OP, 1'b0, 7'h7F});
    res(8'h13, 1'b0, 1'b1, 1'b0);
    op(1'b1, {COPY_REGISTER_OP, 1'b1, 7'h03});
    res(8'h13, 1'b1, 1'b1, 1'b1);
    chk("fwrite_addr", 16'(o_fwrite.addr), 16'h0003);
    chk("fwrite_data", 16'(o_fwrite.data), 16'h0000);
    op(1'b1, {COPY_REGISTER_OP, 1'b1, 7'h7F});
    res(8'h13, 1'b0, 1'b1, 1'b1);
    chk("fwrite_data", 16'(o_fwrite.data), 16'h0013);
  endtask

  task t_refused;
    op(1'b0, {OR_LITERAL_OP, 8'hFF});
    res(8'h13, 1'b0, 1'b0, 1'b0);
    op(1'b1, {6'h0A, 1'b1, 7'h7F});
    res(8'h13, 1'b0, 1'b0, 1'b0);
    chk("fwrite_data", 16'(o_fwrite.data), 16'h0000);
    op(1'b0, 14'h0000);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    n_fail = 0;
    n_checks = 0;
    i_rst = 1'b1;
    i_insn = '0;
    repeat (16) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    res(ACC_RESET, ZERO_RESET, 1'b0, 1'b0);
    t_or_literal_load();
    t_or_register();
    t_copy_register();
    t_refused();
    results();
  end
endmodule
